/* File: adfc_pkg.sv */
// Behaviour
// - Bits 7-6 at offset 0x20 pick the activity engine clock: oscillator, bit clock, control clock pin or custom.
// - Bits 5-4 at offset 0x20 give the external clock: 0 is 24.576, 2 is 12.288, 3 is 18.432 MHz, 1 is reserved and not to be written.
// - Bit 2 at offset 0x20 enables first-phase activity detection through the jack comparator.
// - Bits 7-6 at offset 0x23 pick the limiter input: max, second channel, first channel or average.
// - Bits 5-4 at offset 0x23 pick where gain reduction applies: both, second, first or neither.
// - Bits 7-4 at offset 0x24 enable automatic gain for channels 1 to 4.
// - Bits 3-0 at offset 0x24 enable compression for channels 1 to 4.
// - Bit 7 at offset 0x2B enables the power limiter and bits 6-4 set attenuation in 6 dB steps to -42 dB.
// - Bit 3 at offset 0x2B chooses pin plus field or the analog lookup table as attenuation source.
// - Bit 2 at offset 0x2B allows the limiter to reduce attenuation once the battery recovers.
package adfc_pkg;
  localparam logic [7:0] ADDR_CLOCK_CFG  = 8'h20;
  localparam logic [7:0] ADDR_LIMITER    = 8'h23;
  localparam logic [7:0] ADDR_GAIN_COMP  = 8'h24;
  localparam logic [7:0] ADDR_POWER_LIM  = 8'h2B;
  localparam logic [7:0] MASK_CLOCK_CFG  = 8'hF4;
  localparam logic [7:0] MASK_LIMITER    = 8'hF0;
  localparam logic [7:0] MASK_GAIN_COMP  = 8'hFF;
  localparam logic [7:0] MASK_POWER_LIM  = 8'hFC;
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam int         CLK_SEL_MSB     = 7;
  localparam int         CLK_SEL_LSB     = 6;
  localparam int         EXT_FREQ_MSB    = 5;
  localparam int         EXT_FREQ_LSB    = 4;
  localparam int         PH1_BIT         = 2;
  localparam int         LIM_IN_MSB      = 7;
  localparam int         LIM_IN_LSB      = 6;
  localparam int         LIM_OUT_MSB     = 5;
  localparam int         LIM_OUT_LSB     = 4;
  localparam int         PLIM_EN_BIT     = 7;
  localparam int         PLIM_ATT_MSB    = 6;
  localparam int         PLIM_ATT_LSB    = 4;
  localparam int         PLIM_SRC_BIT    = 3;
  localparam int         PLIM_REC_BIT    = 2;
  localparam logic [1:0] EXT_FREQ_RSVD   = 2'h1;
  localparam logic [5:0] ATTEN_STEP_DB   = 6'h06;
endpackage

/* File: adfc_sample_latch.sv */
`timescale 1ns/1ps
// holds a field and updates it only at a sample boundary
module adfc_sample_latch
  import adfc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_sample_strobe,
  input  wire logic [7:0] i_value,
  output logic      [7:0] o_value
);
  typedef struct packed {
    logic [7:0] value;
  } adfc_latch_state_t;
  adfc_latch_state_t state;
  adfc_latch_state_t next_state;
  always_comb begin
    next_state = state;
    if (i_sample_strobe) begin
      next_state.value = i_value;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state.value <= RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end
  assign o_value = state.value;
  chk_latch_holds: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !$past(i_sample_strobe) && !$past(i_reset) |-> $stable(o_value))
    else $error("field changed off a sample boundary");
endmodule // adfc_sample_latch

/* File: adfc_feature_config_regs.sv */
`timescale 1ns/1ps
module adfc_feature_config_regs
  import adfc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_reg_write,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  input  wire logic       i_sample_strobe,
  output logic      [1:0] o_activity_engine_clock_select,
  output logic      [1:0] o_external_clock_frequency_select,
  output logic            o_first_phase_detect_enable,
  output logic      [1:0] o_limiter_input_select,
  output logic      [1:0] o_limiter_output_select,
  output logic      [3:0] o_auto_gain_enable,
  output logic      [3:0] o_compression_enable,
  output logic            o_power_limiter_enable,
  output logic      [2:0] o_power_limiter_attenuation,
  output logic      [5:0] o_power_limiter_attenuation_db,
  output logic            o_power_limiter_analog_source,
  output logic            o_power_limiter_recovery
);
  typedef struct packed {
    logic [7:0] clock_cfg;
    logic [7:0] limiter;
    logic [7:0] gain_comp;
    logic [7:0] power_lim;
    logic [7:0] rdata;
  } adfc_state_t;

  adfc_state_t state;
  adfc_state_t next_state;
  logic [7:0]  applied_limiter;
  logic [7:0]  applied_gain_comp;
  logic [7:0]  applied_power_lim;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input adfc_state_t s);
    logic [7:0] r;
    r = 8'h00;
    if (addr == ADDR_CLOCK_CFG) begin
      r = s.clock_cfg & MASK_CLOCK_CFG;
    end else if (addr == ADDR_LIMITER) begin
      r = s.limiter & MASK_LIMITER;
    end else if (addr == ADDR_GAIN_COMP) begin
      r = s.gain_comp & MASK_GAIN_COMP;
    end else if (addr == ADDR_POWER_LIM) begin
      r = s.power_lim & MASK_POWER_LIM;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    if (i_reg_write) begin
      if (i_reg_addr == ADDR_CLOCK_CFG) begin
        next_state.clock_cfg = i_reg_wdata & MASK_CLOCK_CFG;
      end else if (i_reg_addr == ADDR_LIMITER) begin
        next_state.limiter = i_reg_wdata & MASK_LIMITER;
      end else if (i_reg_addr == ADDR_GAIN_COMP) begin
        next_state.gain_comp = i_reg_wdata & MASK_GAIN_COMP;
      end else if (i_reg_addr == ADDR_POWER_LIM) begin
        next_state.power_lim = i_reg_wdata & MASK_POWER_LIM;
      end
    end
    next_state.rdata = read_mux(i_reg_addr, next_state);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath fields pass the sample boundary latch
  adfc_sample_latch u_limiter_latch (
    .i_core_clk      (i_core_clk),
    .i_reset         (i_reset),
    .i_sample_strobe (i_sample_strobe),
    .i_value         (state.limiter),
    .o_value         (applied_limiter)
  );
  adfc_sample_latch u_gain_comp_latch (
    .i_core_clk      (i_core_clk),
    .i_reset         (i_reset),
    .i_sample_strobe (i_sample_strobe),
    .i_value         (state.gain_comp),
    .o_value         (applied_gain_comp)
  );
  adfc_sample_latch u_power_lim_latch (
    .i_core_clk      (i_core_clk),
    .i_reset         (i_reset),
    .i_sample_strobe (i_sample_strobe),
    .i_value         (state.power_lim),
    .o_value         (applied_power_lim)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign o_reg_rdata = state.rdata;
  assign o_activity_engine_clock_select    = state.clock_cfg[CLK_SEL_MSB:CLK_SEL_LSB];
  assign o_external_clock_frequency_select = state.clock_cfg[EXT_FREQ_MSB:EXT_FREQ_LSB];
  assign o_first_phase_detect_enable       = state.clock_cfg[PH1_BIT];
  assign o_limiter_input_select            = applied_limiter[LIM_IN_MSB:LIM_IN_LSB];
  assign o_limiter_output_select           = applied_limiter[LIM_OUT_MSB:LIM_OUT_LSB];
  assign o_auto_gain_enable                = applied_gain_comp[7:4];
  assign o_compression_enable              = applied_gain_comp[3:0];
  assign o_power_limiter_enable            = applied_power_lim[PLIM_EN_BIT];
  assign o_power_limiter_attenuation       = applied_power_lim[PLIM_ATT_MSB:PLIM_ATT_LSB];
  // attenuation magnitude in dB, code times six
  assign o_power_limiter_attenuation_db    =
    6'(applied_power_lim[PLIM_ATT_MSB:PLIM_ATT_LSB] * ATTEN_STEP_DB);
  assign o_power_limiter_analog_source     = applied_power_lim[PLIM_SRC_BIT];
  assign o_power_limiter_recovery          = applied_power_lim[PLIM_REC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  chk_clock_select_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_CLOCK_CFG |=>
      o_activity_engine_clock_select == $past(i_reg_wdata[7:6]))
    else $error("clock select not written");
  chk_ext_freq_write: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_CLOCK_CFG |=>
      o_external_clock_frequency_select == $past(i_reg_wdata[5:4]))
    else $error("frequency select not written");
  chk_phase_enable: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_CLOCK_CFG |=>
      o_first_phase_detect_enable == $past(i_reg_wdata[2]) && o_reg_rdata[2] == o_first_phase_detect_enable)
    else $error("phase enable mismatch");
  chk_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_reg_addr == ADDR_CLOCK_CFG |=> o_reg_rdata[3] == 1'b0 && o_reg_rdata[1:0] == 2'h0))
    else $error("reserved bits read nonzero");
  chk_limiter_route: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_sample_strobe |=> {o_limiter_input_select, o_limiter_output_select} == $past(state.limiter[7:4]))
    else $error("limiter routing not applied at boundary");
  chk_unmapped_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == 8'h21 |=> o_reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  chk_gain_apply: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_GAIN_COMP ##1 i_sample_strobe |=>
      {o_auto_gain_enable, o_compression_enable} == $past(i_reg_wdata, 2))
    else $error("gain enables not applied");
  chk_atten_db: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h7 |-> o_power_limiter_attenuation_db == 6'h2A)
    else $error("attenuation scale wrong");

  ////////////////////////////////////////////////////////////////////////////
  // clock group follows the register directly
  chk_clock_select_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !(i_reg_write && i_reg_addr == ADDR_CLOCK_CFG) |=>
      $stable(o_activity_engine_clock_select))
    else $error("clock select moved without a write");
  chk_ext_freq_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !(i_reg_write && i_reg_addr == ADDR_CLOCK_CFG) |=>
      $stable(o_external_clock_frequency_select))
    else $error("frequency select moved without a write");
  chk_phase_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !(i_reg_write && i_reg_addr == ADDR_CLOCK_CFG) |=>
      $stable(o_first_phase_detect_enable))
    else $error("phase enable moved without a write");
  chk_clock_readback: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == ADDR_CLOCK_CFG |=> o_reg_rdata == {o_activity_engine_clock_select,
      o_external_clock_frequency_select, 1'b0, o_first_phase_detect_enable, 2'h0})
    else $error("clock register readback differs from fields");
  chk_clock_masked: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_CLOCK_CFG |=>
      o_reg_rdata == ($past(i_reg_wdata) & MASK_CLOCK_CFG))
    else $error("clock register kept a reserved bit");
  chk_reset_clock: assert property (@(posedge i_core_clk)
    i_reset |=> o_activity_engine_clock_select == 2'h0 &&
      o_external_clock_frequency_select == 2'h0 && !o_first_phase_detect_enable)
    else $error("clock group not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // limiter routing moves only at a sample boundary
  chk_limiter_in_apply: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_LIMITER ##1 i_sample_strobe |=>
      o_limiter_input_select == $past(i_reg_wdata[7:6], 2))
    else $error("limiter input not applied");
  chk_limiter_out_apply: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_LIMITER ##1 i_sample_strobe |=>
      o_limiter_output_select == $past(i_reg_wdata[5:4], 2))
    else $error("limiter output not applied");
  chk_limiter_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_sample_strobe |=>
      $stable(o_limiter_input_select) && $stable(o_limiter_output_select))
    else $error("limiter routing moved off a sample boundary");
  chk_limiter_masked: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_LIMITER |=>
      o_reg_rdata == ($past(i_reg_wdata) & MASK_LIMITER))
    else $error("limiter register kept a reserved bit");
  chk_limiter_reserved: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == ADDR_LIMITER |=>
      o_reg_rdata[3:0] == 4'h0)
    else $error("limiter reserved bits read nonzero");
  chk_limiter_readback: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == ADDR_LIMITER && !i_reg_write |=>
      o_reg_rdata == $past(state.limiter))
    else $error("limiter readback differs from register");
  chk_reset_route: assert property (@(posedge i_core_clk)
    i_reset |=>
      o_limiter_input_select == 2'h0 && o_limiter_output_select == 2'h0)
    else $error("limiter routing not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // per-channel enables move only at a sample boundary
  chk_compress_apply: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_GAIN_COMP ##1 i_sample_strobe |=>
      o_compression_enable == $past(i_reg_wdata[3:0], 2))
    else $error("compression enables not applied");
  chk_gain_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_sample_strobe |=>
      $stable(o_auto_gain_enable))
    else $error("gain enables moved off a sample boundary");
  chk_compress_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_sample_strobe |=>
      $stable(o_compression_enable))
    else $error("compression enables moved off a sample boundary");
  chk_gain_readback: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_GAIN_COMP |=>
      o_reg_rdata == $past(i_reg_wdata))
    else $error("enable register write not read back");
  chk_gain_readback_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == ADDR_GAIN_COMP && !i_reg_write |=>
      o_reg_rdata == $past(state.gain_comp))
    else $error("enable readback differs from register");
  chk_gain_strobe: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_sample_strobe |=>
      o_auto_gain_enable == $past(state.gain_comp[7:4]))
    else $error("gain enables not taken at boundary");
  chk_compress_strobe: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_sample_strobe |=>
      o_compression_enable == $past(state.gain_comp[3:0]))
    else $error("compression enables not taken at boundary");
  chk_reset_enables: assert property (@(posedge i_core_clk)
    i_reset |=>
      o_auto_gain_enable == 4'h0 && o_compression_enable == 4'h0)
    else $error("channel enables not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // power limiter fields move only at a sample boundary
  chk_power_enable: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_POWER_LIM ##1 i_sample_strobe |=>
      o_power_limiter_enable == $past(i_reg_wdata[7], 2))
    else $error("power limiter enable not applied");
  chk_power_atten: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_POWER_LIM ##1 i_sample_strobe |=>
      o_power_limiter_attenuation == $past(i_reg_wdata[6:4], 2))
    else $error("power limiter attenuation not applied");
  chk_power_source: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_POWER_LIM ##1 i_sample_strobe |=>
      o_power_limiter_analog_source == $past(i_reg_wdata[3], 2))
    else $error("power limiter source not applied");
  chk_power_recovery: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_POWER_LIM ##1 i_sample_strobe |=>
      o_power_limiter_recovery == $past(i_reg_wdata[2], 2))
    else $error("power limiter recovery not applied");
  chk_power_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_sample_strobe |=>
      $stable(o_power_limiter_enable) && $stable(o_power_limiter_attenuation))
    else $error("power limiter level moved off a sample boundary");
  chk_power_mode_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i_sample_strobe |=>
      $stable(o_power_limiter_analog_source) && $stable(o_power_limiter_recovery))
    else $error("power limiter mode moved off a sample boundary");
  chk_power_masked: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == ADDR_POWER_LIM |=>
      o_reg_rdata == ($past(i_reg_wdata) & MASK_POWER_LIM))
    else $error("power limiter register kept a reserved bit");
  chk_power_reserved: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == ADDR_POWER_LIM |=>
      o_reg_rdata[1:0] == 2'h0)
    else $error("power limiter reserved bits read nonzero");
  chk_power_readback: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr == ADDR_POWER_LIM && !i_reg_write |=>
      o_reg_rdata == $past(state.power_lim))
    else $error("power limiter readback differs from register");
  chk_reset_power: assert property (@(posedge i_core_clk)
    i_reset |=> !o_power_limiter_enable && o_power_limiter_attenuation == 3'h0 &&
      !o_power_limiter_analog_source && !o_power_limiter_recovery)
    else $error("power limiter not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // attenuation magnitude, one check per code from zero to six
  chk_atten_code_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h0 |-> o_power_limiter_attenuation_db == 6'h00)
    else $error("attenuation scale wrong at code zero");
  chk_atten_code_one: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h1 |-> o_power_limiter_attenuation_db == 6'h06)
    else $error("attenuation scale wrong at code one");
  chk_atten_code_two: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h2 |-> o_power_limiter_attenuation_db == 6'h0C)
    else $error("attenuation scale wrong at code two");
  chk_atten_code_three: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h3 |-> o_power_limiter_attenuation_db == 6'h12)
    else $error("attenuation scale wrong at code three");
  chk_atten_code_four: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h4 |-> o_power_limiter_attenuation_db == 6'h18)
    else $error("attenuation scale wrong at code four");
  chk_atten_code_five: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h5 |-> o_power_limiter_attenuation_db == 6'h1E)
    else $error("attenuation scale wrong at code five");
  chk_atten_code_six: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_power_limiter_attenuation == 3'h6 |-> o_power_limiter_attenuation_db == 6'h24)
    else $error("attenuation scale wrong at code six");

  ////////////////////////////////////////////////////////////////////////////
  // unmapped addresses neither store nor return data
  chk_unmapped_ignore: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_write && i_reg_addr == 8'h21 |=>
      state.clock_cfg == $past(state.clock_cfg) && state.limiter == $past(state.limiter) &&
      state.gain_comp == $past(state.gain_comp) && state.power_lim == $past(state.power_lim))
    else $error("unmapped write changed a register");
  chk_unmapped_read: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_reg_addr != ADDR_CLOCK_CFG && i_reg_addr != ADDR_LIMITER &&
      i_reg_addr != ADDR_GAIN_COMP && i_reg_addr != ADDR_POWER_LIM |=> o_reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  chk_reset_rdata: assert property (@(posedge i_core_clk)
    i_reset |=>
      o_reg_rdata == 8'h00)
    else $error("read data not cleared by reset");
endmodule // adfc_feature_config_regs

/* File: adfc_host_model.sv */
`timescale 1ns/1ps
module adfc_host_model
  import adfc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_reg_rdata,
  output logic            o_reg_write,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  initial begin
    o_reg_write = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // raw set keeps reserved ones, to probe the device
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic raw);
    logic [7:0] m;
    m = (a == ADDR_CLOCK_CFG) ? MASK_CLOCK_CFG : (a == ADDR_LIMITER) ? MASK_LIMITER :
        (a == ADDR_POWER_LIM) ? MASK_POWER_LIM : MASK_GAIN_COMP;
    @(negedge i_core_clk);
    o_reg_write = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = raw ? v : (v & m);
    @(negedge i_core_clk);
    o_reg_write = 1'b0;
    o_reg_wdata = ~o_reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_core_clk);
    o_reg_addr = a;
    @(negedge i_core_clk);
    v = i_reg_rdata;
  endtask
endmodule // adfc_host_model

/* File: tb_audio_dsp_feature_config_regs.sv */
`timescale 1ns/1ps
module tb_audio_dsp_feature_config_regs;
  import adfc_pkg::*;
  logic       i_core_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_sample_strobe = 1'b0;
  logic       i_reg_write;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, d, p;
  logic [1:0] o_activity_engine_clock_select, o_external_clock_frequency_select, f;
  logic [1:0] o_limiter_input_select, o_limiter_output_select;
  logic [3:0] o_auto_gain_enable, o_compression_enable;
  logic [2:0] o_power_limiter_attenuation;
  logic [5:0] o_power_limiter_attenuation_db;
  logic       o_first_phase_detect_enable, o_power_limiter_enable;
  logic       o_power_limiter_analog_source, o_power_limiter_recovery;
  int         n_mismatch = 0;
  int         check_count = 0;
  logic [7:0] g [2] = '{8'hA5, 8'h5A};
  always #10 i_core_clk = ~i_core_clk;
  adfc_feature_config_regs i_dut (.i_core_clk, .i_reset, .i_reg_write, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_sample_strobe, .o_activity_engine_clock_select,
    .o_external_clock_frequency_select, .o_first_phase_detect_enable,
    .o_limiter_input_select, .o_limiter_output_select, .o_auto_gain_enable,
    .o_compression_enable, .o_power_limiter_enable, .o_power_limiter_attenuation,
    .o_power_limiter_attenuation_db, .o_power_limiter_analog_source,
    .o_power_limiter_recovery);
  adfc_host_model i_host (.i_core_clk, .i_reg_rdata(o_reg_rdata),
    .o_reg_write(i_reg_write), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata));
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // caller stands on a falling edge, so the pulse meets the edge after a write
  task automatic strobe();
    i_sample_strobe = 1'b1;
    @(negedge i_core_clk);
    i_sample_strobe = 1'b0;
    @(negedge i_core_clk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #(20 * 2000);
    n_mismatch++;
    conclude();
  end
  initial begin
    int i;
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_reset = 1'b0;
    i_host.rd(ADDR_POWER_LIM, d);
    check(d, RESET_VALUE);
    check({o_auto_gain_enable, o_compression_enable}, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      f = (2'(i) == EXT_FREQ_RSVD) ? 2'h0 : 2'(i);
      i_host.wr(ADDR_CLOCK_CFG, {2'(i), f, 1'b1, i[0], 2'b11}, 1'b1);
      check({6'h00, o_activity_engine_clock_select}, 8'(i));
      check({6'h00, o_external_clock_frequency_select}, {6'h00, f});
      check({7'h00, o_first_phase_detect_enable}, {7'h00, i[0]});
      i_host.rd(ADDR_CLOCK_CFG, d);
      check(d, {2'(i), f, 1'b0, i[0], 2'b00});
    end
    $display("test clock config done");
    p = 8'h00;
    for (i = 0; i < 4; i++) begin
      i_host.wr(ADDR_LIMITER, {2'(i), 2'(3 - i), 4'hF}, 1'b0);
      check({4'h0, o_limiter_input_select, o_limiter_output_select}, p);
      strobe();
      p = {4'h0, 2'(i), 2'(3 - i)};
      check({4'h0, o_limiter_input_select, o_limiter_output_select}, p);
      i_host.rd(ADDR_LIMITER, d);
      check(d, {p[3:0], 4'h0});
    end
    $display("test limiter done");
    foreach (g[k]) begin
      i_host.wr(ADDR_GAIN_COMP, g[k], 1'b0);
      strobe();
      check({o_auto_gain_enable, o_compression_enable}, g[k]);
    end
    $display("test gain done");
    for (i = 0; i < 8; i++) begin
      i_host.wr(ADDR_POWER_LIM, {i[0], 3'(i), i[1], i[2], 2'b11}, 1'b0);
      strobe();
      check({o_power_limiter_enable, o_power_limiter_attenuation, o_power_limiter_analog_source,
             o_power_limiter_recovery, 2'b00}, {i[0], 3'(i), i[1], i[2], 2'b00});
      check({2'b00, o_power_limiter_attenuation_db}, 8'(i * 6));
      i_host.rd(ADDR_POWER_LIM, d);
      check(d, {i[0], 3'(i), i[1], i[2], 2'b00});
    end
    $display("test power limiter done");
    i_host.wr(8'h21, 8'hFF, 1'b1);
    i_host.rd(8'h21, d);
    check(d, 8'h00);
    i_host.rd(ADDR_GAIN_COMP, d);
    check(d, 8'h5A);
    $display("test unmapped done");
    conclude();
  end
endmodule // tb_audio_dsp_feature_config_regs
